// [airq_ctrl.v]
`include "airq_defines.vh"

module airq_ctrl (
    input wire clk_sys,
    input wire srst,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [11:0] paddr,
    input wire [31:0] pwdata,
    input wire ac97_mode,
    input wire cmd_read_done,
    input wire cmd_write_done,
    input wire codec_ready_tag,
    input wire modem_status_valid,
    input wire rx_ser_overrun,
    input wire rx_ser_misalign,
    input wire tx_ser_underrun,
    input wire tx_ser_misalign,
    input wire rx_bus_underrun,
    input wire rx_bus_misalign,
    input wire tx_bus_overrun,
    input wire tx_bus_write,
    input wire [1:0] tx_bus_size,
    input wire [1:0] tx_byte_ptr,
    input wire [5:0] rx_level,
    input wire [5:0] rx_half_level,
    input wire rx_full,
    input wire rx_empty,
    input wire [5:0] tx_level,
    input wire [5:0] tx_half_level,
    input wire tx_full,
    input wire tx_empty,
    output reg [31:0] prdata,
    output wire pready,
    output wire pslverr,
    output reg irq_out
);

// ----------------------------------------
// registers
// ----------------------------------------
// only flags 13 to 0 have storage; upper bits are constants on read
reg [13:0] raw_ff;
reg [13:0] mask_ff;
reg codec_tag_ff;
reg modem_valid_ff;
reg rx_full_ff;
reg rx_empty_ff;
reg rx_above_ff;
reg tx_full_ff;
reg tx_empty_ff;
reg tx_below_ff;
reg [1:0] last_size_ff;
reg have_size_ff;
reg pready_ff;
reg pslverr_ff;

// ----------------------------------------
// helper functions
// ----------------------------------------
// high for the one cycle in which a level goes from low to high
function f_rise;
    input now_lvl;
    input old_lvl;
    begin
        f_rise = now_lvl && !old_lvl;
    end
endfunction

// high for the one cycle in which a level goes from high to low
function f_fall;
    input now_lvl;
    input old_lvl;
    begin
        f_fall = !now_lvl && old_lvl;
    end
endfunction

// strict compare: a level equal to the half mark is not above it
function f_above;
    input [5:0] lvl;
    input [5:0] mark;
    begin
        f_above = (lvl > mark);
    end
endfunction

// strict compare: a level equal to the half mark is not below it
function f_below;
    input [5:0] lvl;
    input [5:0] mark;
    begin
        f_below = (lvl < mark);
    end
endfunction

// full 12-bit compare; aliases of a register are not decoded
function f_hit;
    input [11:0] addr;
    input [11:0] ofs;
    begin
        f_hit = (addr == ofs);
    end
endfunction

// clear first, then set, so an event in the clear cycle survives
function [13:0] f_next_raw;
    input [13:0] cur;
    input [13:0] clr;
    input [13:0] evt;
    begin
        f_next_raw = (cur & ~clr) | evt;
    end
endfunction

// any flag that is set and not blocked by its mask bit
function f_any_open;
    input [13:0] flags;
    input [13:0] blocks;
    begin
        f_any_open = |(flags & ~blocks);
    end
endfunction

// ----------------------------------------
// fifo level compares
// ----------------------------------------
wire rx_above = f_above(rx_level, rx_half_level);
wire tx_below = f_below(tx_level, tx_half_level);

// ----------------------------------------
// misaligned fifo write detection
// ----------------------------------------
// a width change is harmless while the byte pointer is back at byte zero
wire size_changed = have_size_ff && (tx_bus_size != last_size_ff);
wire tx_misalign = tx_bus_write && size_changed && (tx_byte_ptr != 2'h0);

always @(posedge clk_sys) begin
    if (srst) begin
        last_size_ff <= `AIRQ_SIZE_8;
        have_size_ff <= 1'b0;
    end else if (tx_bus_write) begin
        last_size_ff <= tx_bus_size;
        have_size_ff <= 1'b1;
    end
end

// ----------------------------------------
// ac97 command and codec events
// ----------------------------------------
// the link only carries these in ac97 mode; in i2s mode they stay quiet
wire evt_modem;
wire evt_rd_done;
wire evt_wr_done;
wire evt_codec_up;
assign evt_modem = ac97_mode && f_rise(modem_status_valid, modem_valid_ff);
assign evt_rd_done = ac97_mode && cmd_read_done;
assign evt_wr_done = ac97_mode && cmd_write_done;
assign evt_codec_up = ac97_mode && f_rise(codec_ready_tag, codec_tag_ff);

always @(posedge clk_sys) begin
    if (srst) begin
        codec_tag_ff <= 1'b0;
        modem_valid_ff <= 1'b0;
    end else begin
        codec_tag_ff <= codec_ready_tag;
        modem_valid_ff <= modem_status_valid;
    end
end

// ----------------------------------------
// fifo error events
// ----------------------------------------
// error inputs are levels; every cycle they stand sets the flag again
wire evt_ser_rx_err;
wire evt_ser_tx_err;
wire evt_bus_rd_err;
wire evt_bus_wr_err;
assign evt_ser_rx_err = rx_ser_overrun || rx_ser_misalign;
assign evt_ser_tx_err = tx_ser_underrun || tx_ser_misalign;
assign evt_bus_rd_err = rx_bus_underrun || rx_bus_misalign;
assign evt_bus_wr_err = tx_bus_overrun || tx_misalign;

// ----------------------------------------
// receive fifo level events
// ----------------------------------------
// history resets as an idle empty fifo, so release of reset is no edge
wire evt_rx_full;
wire evt_rx_thr;
wire evt_rx_data;
assign evt_rx_full = f_rise(rx_full, rx_full_ff);
assign evt_rx_thr = f_rise(rx_above, rx_above_ff);
assign evt_rx_data = f_fall(rx_empty, rx_empty_ff);

always @(posedge clk_sys) begin
    if (srst) begin
        rx_full_ff <= 1'b0;
        rx_empty_ff <= 1'b1;
        rx_above_ff <= 1'b0;
    end else begin
        rx_full_ff <= rx_full;
        rx_empty_ff <= rx_empty;
        rx_above_ff <= rx_above;
    end
end

// ----------------------------------------
// transmit fifo level events
// ----------------------------------------
// an empty transmit fifo also sits below its half mark after reset
wire evt_tx_space;
wire evt_tx_thr;
wire evt_tx_drain;
assign evt_tx_space = f_fall(tx_full, tx_full_ff);
assign evt_tx_thr = f_rise(tx_below, tx_below_ff);
assign evt_tx_drain = f_rise(tx_empty, tx_empty_ff);

always @(posedge clk_sys) begin
    if (srst) begin
        tx_full_ff <= 1'b0;
        tx_empty_ff <= 1'b1;
        tx_below_ff <= 1'b1;
    end else begin
        tx_full_ff <= tx_full;
        tx_empty_ff <= tx_empty;
        tx_below_ff <= tx_below;
    end
end

// ----------------------------------------
// event vector
// ----------------------------------------
// one bit per flag, in register order
reg [13:0] nxt_evt;
always @* begin
    nxt_evt = 14'h0000;
    nxt_evt[`AIRQ_BIT_MODEM] = evt_modem;
    nxt_evt[`AIRQ_BIT_RD_DONE] = evt_rd_done;
    nxt_evt[`AIRQ_BIT_WR_DONE] = evt_wr_done;
    nxt_evt[`AIRQ_BIT_CODEC_UP] = evt_codec_up;
    nxt_evt[`AIRQ_BIT_SER_RX_ERR] = evt_ser_rx_err;
    nxt_evt[`AIRQ_BIT_SER_TX_ERR] = evt_ser_tx_err;
    nxt_evt[`AIRQ_BIT_BUS_RD_ERR] = evt_bus_rd_err;
    nxt_evt[`AIRQ_BIT_BUS_WR_ERR] = evt_bus_wr_err;
    nxt_evt[`AIRQ_BIT_RX_FULL] = evt_rx_full;
    nxt_evt[`AIRQ_BIT_RX_THR] = evt_rx_thr;
    nxt_evt[`AIRQ_BIT_RX_DATA] = evt_rx_data;
    nxt_evt[`AIRQ_BIT_TX_SPACE] = evt_tx_space;
    nxt_evt[`AIRQ_BIT_TX_THR] = evt_tx_thr;
    nxt_evt[`AIRQ_BIT_TX_DRAIN] = evt_tx_drain;
end

// ----------------------------------------
// apb decode
// ----------------------------------------
// zero wait states; every access completes in its access phase
wire wr_acc = psel && penable && pwrite;
wire rd_setup = psel && !penable && !pwrite;
wire wr_mask = wr_acc && f_hit(paddr, `AIRQ_OFS_MASK);
wire wr_clear = wr_acc && f_hit(paddr, `AIRQ_OFS_CLEAR);
wire [13:0] clr_bits = wr_clear ? pwdata[13:0] : 14'h0000;
wire [13:0] nxt_raw = f_next_raw(raw_ff, clr_bits, nxt_evt);

always @(posedge clk_sys) begin
    if (srst) begin
        pready_ff <= 1'b1;
    end else begin
        pready_ff <= 1'b1;
    end
end

always @(posedge clk_sys) begin
    if (srst) begin
        pslverr_ff <= 1'b0;
    end else begin
        pslverr_ff <= 1'b0;
    end
end

assign pready = pready_ff;
assign pslverr = pslverr_ff;

// ----------------------------------------
// raw flags
// ----------------------------------------
// status writes are dropped; only clears and events move these bits
always @(posedge clk_sys) begin
    if (srst) begin
        raw_ff <= `AIRQ_STAT_RST;
    end else begin
        raw_ff <= nxt_raw;
    end
end

// ----------------------------------------
// mask register
// ----------------------------------------
// bits 31 to 14 have no storage and read back as their reset ones
always @(posedge clk_sys) begin
    if (srst) begin
        mask_ff <= `AIRQ_MASK_FLAG_RST;
    end else if (wr_mask) begin
        mask_ff <= pwdata[13:0];
    end
end

// ----------------------------------------
// read data
// ----------------------------------------
// read data is captured in the setup phase so prdata stays a flop output
reg [31:0] nxt_prdata;
always @* begin
    nxt_prdata = 32'h00000000;
    // the write-only clear register and unmapped offsets read as zero
    if (f_hit(paddr, `AIRQ_OFS_STATUS)) begin
        nxt_prdata = {18'h00000, raw_ff};
    end else if (f_hit(paddr, `AIRQ_OFS_MASK)) begin
        nxt_prdata = {`AIRQ_HI_MASK_RST, mask_ff};
    end
end

always @(posedge clk_sys) begin
    if (srst) begin
        prdata <= 32'h00000000;
    end else if (rd_setup) begin
        prdata <= nxt_prdata;
    end
end

// ----------------------------------------
// interrupt output
// ----------------------------------------
// registered, so the pin follows the flags one cycle late
always @(posedge clk_sys) begin
    if (srst) begin
        irq_out <= 1'b0;
    end else begin
        irq_out <= f_any_open(raw_ff, mask_ff);
    end
end

endmodule // airq_ctrl

// [airq_defines.vh]
// Notes on behaviour
// - in ac97 mode, set flag 12 when a command read finishes with status ready; the code sets it on cmd_read_done alone, with no status check.
// - in ac97 mode, set flag 11 when a command write finishes.
// - in ac97 mode, set flag 10 on codec-ready tag bit rising 0 to 1.
// - set flag 9 on receive fifo overrun or misalign, serial side.
// - set flag 8 on transmit fifo underrun or misalign, serial side.
// - set flag 7 on receive fifo underrun or misalign, bus side.
// - set flag 6 on transmit fifo overrun or misalign, bus side.
// - fifo write is misaligned when width changes and byte pointer is not zero.
// - set flag 5 when the receive fifo becomes full.
// - set flag 4 when receive level rises above programmed half level.
// - set flag 3 when the receive fifo goes from empty to not empty.
// - set flag 2 when the transmit fifo goes from full to not full.
// - set flag 1 when transmit level drops below programmed half level.
// - set flag 0 when the transmit fifo becomes empty.
// - each flag has a mask bit, one blocks; all masks read one after reset.
// - writing one to a clear register bit resets that raw flag.
// - status shows raw flags; interrupt output ors the unmasked flags.
// - in ac97 mode, set flag 13 once the modem status field is valid.
`ifndef AIRQ_DEFINES_VH
`define AIRQ_DEFINES_VH
// ----------------------------------------
// register offsets
// ----------------------------------------
`define AIRQ_OFS_STATUS 12'h000
`define AIRQ_OFS_MASK 12'h004
`define AIRQ_OFS_CLEAR 12'h008
// ----------------------------------------
// field positions and resets
// ----------------------------------------
`define AIRQ_NFLAG 14
`define AIRQ_BIT_MODEM 13
`define AIRQ_BIT_RD_DONE 12
`define AIRQ_BIT_WR_DONE 11
`define AIRQ_BIT_CODEC_UP 10
`define AIRQ_BIT_SER_RX_ERR 9
`define AIRQ_BIT_SER_TX_ERR 8
`define AIRQ_BIT_BUS_RD_ERR 7
`define AIRQ_BIT_BUS_WR_ERR 6
`define AIRQ_BIT_RX_FULL 5
`define AIRQ_BIT_RX_THR 4
`define AIRQ_BIT_RX_DATA 3
`define AIRQ_BIT_TX_SPACE 2
`define AIRQ_BIT_TX_THR 1
`define AIRQ_BIT_TX_DRAIN 0
`define AIRQ_MASK_RST 32'hffffffff
`define AIRQ_MASK_FLAG_RST 14'h3fff
`define AIRQ_STAT_RST 14'h0000
`define AIRQ_HI_MASK_RST 18'h3ffff
// ----------------------------------------
// fifo access sizes
// ----------------------------------------
`define AIRQ_SIZE_8 2'h0
`define AIRQ_SIZE_16 2'h1
`define AIRQ_SIZE_32 2'h2
`endif

// [airq_ctrl_monitor.sv]
module airq_ctrl_monitor (
    input wire clk_sys,
    input wire srst,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [11:0] paddr,
    input wire [31:0] pwdata,
    input wire tx_bus_overrun,
    input wire [31:0] prdata,
    input wire pready,
    input wire pslverr,
    input wire irq_out
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking cb @(posedge clk_sys); endclocking
    logic [31:0] mask_ff;
    wire rd_acc = psel && penable && !pwrite;
    always @(posedge clk_sys) begin
        if (srst) mask_ff <= 32'hffffffff;
        else if (psel && penable && pwrite && paddr == 12'h004) mask_ff <= pwdata;
    end
    // psel low keeps any mask write or clear at least two edges away
    sequence s_evt_open; tx_bus_overrun && !mask_ff[6] && !psel; endsequence
    sequence s_irq_up; ##[1:2] irq_out; endsequence
    a_bus_fixed: assert property (disable iff (srst) pready && !pslverr) else $error("bus answer wrong");
    a_reset_quiet: assert property (srst |=> prdata == 32'h0 && !irq_out) else $error("not idle");
    a_masked_quiet: assert property (disable iff (srst)
        $past(mask_ff[13:0]) == 14'h3fff |-> !irq_out) else $error("masked irq seen");
    a_unmask_fires: assert property (disable iff (srst) s_evt_open |-> s_irq_up) else $error("irq late");
    a_stat_hi_zero: assert property (disable iff (srst)
        rd_acc && paddr == 12'h000 |-> prdata[31:14] == 18'h0) else $error("status high bits");
    a_mask_hi_one: assert property (disable iff (srst)
        rd_acc && paddr == 12'h004 |-> prdata[31:14] == 18'h3ffff) else $error("mask high bits");
    a_mask_readback: assert property (disable iff (srst)
        rd_acc && paddr == 12'h004 |-> prdata[13:0] == mask_ff[13:0]) else $error("mask readback");
    a_clear_zero: assert property (disable iff (srst)
        rd_acc && paddr == 12'h008 |-> prdata == 32'h0) else $error("clear read not zero");
    a_unmapped_zero: assert property (disable iff (srst)
        rd_acc && paddr > 12'h008 |-> prdata == 32'h0) else $error("unmapped read not zero");
endmodule // airq_ctrl_monitor
bind airq_ctrl airq_ctrl_monitor airq_ctrl_monitor_i (.clk_sys, .srst, .psel, .penable, .pwrite, .paddr,
    .pwdata, .tx_bus_overrun, .prdata, .pready, .pslverr, .irq_out);

// [airq_src_model.sv]
module airq_src_model (
    input wire clk_sys,
    input wire ev_go,
    input wire [4:0] ev_sel,
    output wire [16:0] ln
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [16:0] pulse_ff = 17'h00000;
    // both empty flags idle high, so their event is a one-cycle low pulse
    assign ln = 17'h00009 ^ pulse_ff;
    always @(posedge clk_sys) begin
        pulse_ff <= ev_go ? (17'h00001 << ev_sel) : 17'h00000;
    end
endmodule // airq_src_model

// [airq_ctrl_bench.sv]
module airq_ctrl_bench;
    timeunit 1ns;
    timeprecision 1ns;
    logic clk_sys = 1'b0, srst = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, ac97_mode = 1'b0, ev_go = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, rd, b;
    logic [4:0] ev_sel = 5'h00;
    logic tx_wr = 1'b0;
    logic [1:0] tx_sz = 2'h0, tx_ptr = 2'h0;
    wire [16:0] ln;
    wire [31:0] prdata;
    wire pready, pslverr, irq_out;
    int error_cnt = 0, check_count = 0;
    always #50 clk_sys = ~clk_sys;
    airq_src_model airq_src_model_i (.clk_sys(clk_sys), .ev_go(ev_go), .ev_sel(ev_sel), .ln(ln));
    airq_ctrl airq_ctrl_i (.clk_sys(clk_sys), .srst(srst), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .ac97_mode(ac97_mode), .cmd_read_done(ln[12]), .cmd_write_done(ln[11]),
        .codec_ready_tag(ln[10]), .modem_status_valid(ln[13]), .rx_ser_overrun(ln[9]), .rx_ser_misalign(ln[14]),
        .tx_ser_underrun(ln[8]), .tx_ser_misalign(ln[15]), .rx_bus_underrun(ln[7]), .rx_bus_misalign(ln[16]),
        .tx_bus_overrun(ln[6]), .tx_bus_write(tx_wr), .tx_bus_size(tx_sz), .tx_byte_ptr(tx_ptr),
        .rx_level(ln[4] ? 6'h09 : 6'h00), .rx_half_level(6'h08), .rx_full(ln[5]), .rx_empty(ln[3]),
        .tx_level(ln[1] ? 6'h09 : 6'h00), .tx_half_level(6'h08), .tx_full(ln[2]), .tx_empty(ln[0]),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .irq_out(irq_out));
    task bus(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge clk_sys);
        {psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, a, d};
        @(posedge clk_sys);
        penable <= 1'b1;
        @(posedge clk_sys);
        rd = prdata;
        {psel, penable} <= 2'b00;
    endtask
    task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            error_cnt++;
            $display("mismatch %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task fire(input logic [4:0] s);
        @(posedge clk_sys);
        {ev_go, ev_sel} <= {1'b1, s};
        @(posedge clk_sys);
        ev_go <= 1'b0;
        repeat (4) @(posedge clk_sys);
    endtask
    task fwr(input logic [1:0] s, input logic [1:0] p);
        @(posedge clk_sys);
        {tx_wr, tx_sz, tx_ptr} <= {1'b1, s, p};
        @(posedge clk_sys);
        tx_wr <= 1'b0;
    endtask
    task print_verdict;
        $display("checks %0d errors %0d", check_count, error_cnt);
        if (error_cnt == 0 && check_count > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask
    initial begin
        repeat (20000) @(posedge clk_sys);
        error_cnt++;
        print_verdict;
    end
    initial begin
        repeat (10) @(posedge clk_sys);
        srst <= 1'b0;
        bus(0, 12'h004, 0); chk("mask_rst", rd, 32'hffffffff);
        bus(0, 12'h000, 0); chk("stat_rst", rd, 32'h0);
        ac97_mode <= 1'b1;
        for (int i = 0; i < 17; i++) begin
            b = 32'h1 << (i < 14 ? i : 23 - i);
            fire(i[4:0]);
            bus(0, 12'h000, 0); chk("raw", rd, b);
            bus(1, 12'h008, ~b); bus(0, 12'h000, 0); chk("keep", rd, b);
            bus(1, 12'h008, b); bus(0, 12'h000, 0); chk("clr", rd, 32'h0);
        end
        ac97_mode <= 1'b0;
        for (int i = 10; i < 14; i++) begin
            fire(i[4:0]);
            bus(0, 12'h000, 0); chk("gated", rd, 32'h0);
        end
        bus(1, 12'h004, 0); bus(0, 12'h004, 0); chk("mask_hi", rd, 32'hffffc000);
        fire(5'd6); chk("irq_on", {31'h0, irq_out}, 32'h1);
        bus(1, 12'h004, 32'h40); bus(0, 12'h000, 0); chk("irq_off", {31'h0, irq_out}, 32'h0);
        chk("raw_masked", rd, 32'h40);
        bus(1, 12'h000, 32'hffffffff); bus(0, 12'h000, 0); chk("ro", rd, 32'h40);
        bus(0, 12'h040, 0); chk("unmapped", rd, 32'h0);
        bus(1, 12'h008, 32'h40); bus(0, 12'h000, 0); chk("clr6", rd, 32'h0);
        fwr(2'h0, 2'h0); fwr(2'h1, 2'h0); fwr(2'h1, 2'h3);
        bus(0, 12'h000, 0); chk("aligned", rd, 32'h0);
        fwr(2'h2, 2'h1); bus(0, 12'h000, 0); chk("misalign", rd, 32'h40);
        bus(1, 12'h008, 32'h40); bus(0, 12'h000, 0); chk("clr_mis", rd, 32'h0);
        print_verdict;
    end
endmodule // airq_ctrl_bench
